// >>> src/spc_top.sv
// sector protect control: command matcher, pin filter, permission checks
// What this block does
// - enable only on 3D 2A 7F A9
// - disable only on 3D 2A 7F 9A
// - enable takes effect at chip-select rise
// - disable takes effect at chip-select rise
// - software protection cleared at power-up
// - protection blocks flagged sector program/erase
// - pin low locks flagged sectors and register
// - pin high lets register be modified
// - pin low forces protection on quickly
// - pin release clears protection if no enable
// - enable before/during low survives release
// - disable ignored while pin low
// - pin filtered against short glitches
// - effective protection reported as status bit
// - sixteen bytes, FFh protected, 00h not
`timescale 1ns/10ps
`default_nettype none
`include "spc_defines.svh"

module spc_top
	import spc_pkg::*;
(
	// clock, reset, enable
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       ce,
	// serial pins
	input  wire logic       spi_sck,
	input  wire logic       spi_cs_n,
	input  wire logic       spi_mosi,
	input  wire logic       wp_n,
	// program/erase request from the array engines
	input  wire logic       op_req,
	input  wire logic       op_on_spr,
	input  wire logic [3:0] op_sector,
	input  wire logic       op_sub0b,
	output logic            op_grant,
	output logic            op_deny,
	// protection register load from its program engine
	input  wire logic       spr_wr,
	input  wire logic [3:0] spr_wr_idx,
	input  wire logic [7:0] spr_wr_data,
	// status
	output logic            prot_status,
	output logic            sw_prot_on,
	output logic            spr_writable
);

	localparam logic [`SPC_FILT_W-1:0] FILT_LAST = `SPC_FILT_W'(`SPC_WP_FILT_CYC - 1);

	spc_link_if lk ();

	spc_spi_rx u_rx (
		.ref_clk  (ref_clk),
		.arst_n   (arst_n),
		.ce       (ce),
		.spi_sck  (spi_sck),
		.spi_cs_n (spi_cs_n),
		.spi_mosi (spi_mosi),
		.wp_n     (wp_n),
		.lk       (lk.rx)
	);

	spc_core_s q;
	spc_core_s d;
	logic      seq_ok;
	logic      flagged;
	logic      blocked;
	logic [7:0] sel;

	// a sequence counts only if exactly four whole bytes matched
	assign seq_ok = (q.cnt == `SPC_OP_LEN) && !q.bad && !lk.partial;

	// per-sector flag; sector 0 splits into two 2-bit fields
	always_comb begin
		sel = q.spr[op_sector];
		if (op_sector == 4'h0) begin
			flagged = op_sub0b ? (sel[`SPC_S0B_HI:`SPC_S0B_LO] == `SPC_S0_FIELD_PROT)
			                   : (sel[`SPC_S0A_HI:`SPC_S0A_LO] == `SPC_S0_FIELD_PROT);
		end else begin
			flagged = (sel == `SPC_SPR_PROT);
		end
		// register itself locked only by the pin
		blocked = op_on_spr ? q.wp_low : (flagged && (q.sw_en || q.wp_low));
	end

	// next state
	always_comb begin
		d       = q;
		d.grant = 1'b0;
		d.deny  = 1'b0;
		if (lk.byte_v) begin
			if (q.cnt < `SPC_OP_LEN) begin
				d.cnt = q.cnt + 3'h1;
				unique case (q.cnt)
					3'h0: begin
						if (lk.byte_data != `SPC_OP_B0) d.bad = 1'b1;
					end
					3'h1: begin
						if (lk.byte_data != `SPC_OP_B1) d.bad = 1'b1;
					end
					3'h2: begin
						if (lk.byte_data != `SPC_OP_B2) d.bad = 1'b1;
					end
					3'h3: begin
						// disable differs only in its last byte
						if (lk.byte_data == `SPC_OP_EN_B3) d.cmd = SPC_CMD_EN;
						else if (lk.byte_data == `SPC_OP_DIS_B3) d.cmd = SPC_CMD_DIS;
						else d.bad = 1'b1;
					end
					default: d.bad = 1'b1;
				endcase
			end else begin
				d.bad = 1'b1;
			end
		end
		// commit on deselect; a byte in the same cycle is lost
		if (lk.cs_rise) begin
			// enable taken even under the pin
			if (seq_ok && q.cmd == SPC_CMD_EN) begin
				d.sw_en = 1'b1;
			// disable has no effect under the pin
			end else if (seq_ok && q.cmd == SPC_CMD_DIS && !q.wp_low) begin
				d.sw_en = 1'b0;
			end
			d.cnt = 3'h0;
			d.bad = 1'b0;
			d.cmd = SPC_CMD_NONE;
		end
		// filter needs a stable run of samples to flip
		if ((!lk.wp_n) != q.wp_low) begin
			if (q.filt_cnt == FILT_LAST) begin
				d.wp_low   = !lk.wp_n;
				d.filt_cnt = '0;
			end else begin
				d.filt_cnt = q.filt_cnt + `SPC_FILT_W'(1);
			end
		end else begin
			d.filt_cnt = '0;
		end
		// release leaves only the software state, which keeps
		d.prot_status = q.sw_en || q.wp_low;
		// register writable only with pin high
		d.spr_wr_ok = !q.wp_low;
		// register bytes, loaded only while writable
		if (spr_wr && !q.wp_low) begin
			d.spr[spr_wr_idx] = spr_wr_data;
		end
		if (op_req) begin
			d.grant = !blocked;
			d.deny  = blocked;
		end
	end

	// software state resets cleared, register bytes to 00h
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign op_grant     = q.grant;
	assign op_deny      = q.deny;
	// status bit is pin or software
	assign prot_status  = q.prot_status;
	assign sw_prot_on   = q.sw_en;
	assign spr_writable = q.spr_wr_ok;

	// checks; they assume ce stays high
	sequence accept_en_s;
		lk.cs_rise && seq_ok && q.cmd == SPC_CMD_EN;
	endsequence

	sequence accept_dis_s;
		lk.cs_rise && seq_ok && q.cmd == SPC_CMD_DIS && !q.wp_low;
	endsequence

	sw_set_on_cs_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		accept_en_s |=> sw_prot_on ##1 prot_status)
		else $error("enable sequence did not set protection");

	sw_clr_on_cs_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		accept_dis_s |=> !sw_prot_on)
		else $error("disable sequence did not clear protection");

	sw_change_cause_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$changed(sw_prot_on) |-> $past(lk.cs_rise) && $past(seq_ok))
		else $error("software state changed without a whole sequence");

	dis_under_pin_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$fell(sw_prot_on) |-> !$past(q.wp_low))
		else $error("disable acted while pin filtered low");

	glitch_filter_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		$changed(q.wp_low) |-> $past(q.filt_cnt) == FILT_LAST)
		else $error("pin state flipped before filter run completed");

	pin_on_time_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(!lk.wp_n && !q.wp_low && q.filt_cnt == FILT_LAST) |=> ##1 prot_status && !spr_writable)
		else $error("pin assertion did not force protection");

	pin_off_time_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(lk.wp_n && q.wp_low && q.filt_cnt == FILT_LAST && !q.sw_en && !lk.cs_rise)
		|=> ##1 !prot_status)
		else $error("pin release did not clear protection");

	status_or_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		prot_status == $past(q.sw_en || q.wp_low))
		else $error("status bit disagrees with pin and software state");

	flag_deny_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(op_req && !op_on_spr && op_sector != 4'h0 && q.spr[op_sector] == `SPC_SPR_PROT
		 && q.sw_en) |=> op_deny && !op_grant)
		else $error("flagged sector not refused while protected");

	spr_lock_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(spr_wr && q.wp_low) |=> $stable(q.spr))
		else $error("register changed while pin low");

	spr_pin_high_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(op_req && op_on_spr && !q.wp_low) |=> op_grant)
		else $error("register operation refused with pin high");

endmodule : spc_top

`default_nettype wire

// >>> src/spc_defines.svh
// constants for the sector protect control block
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// clock
`define SPC_CLK_PERIOD_NS     10

// four-byte command opcodes
`define SPC_OP_B0             8'h3D
`define SPC_OP_B1             8'h2A
`define SPC_OP_B2             8'h7F
`define SPC_OP_EN_B3          8'hA9
`define SPC_OP_DIS_B3         8'h9A
`define SPC_OP_LEN            3'h4

// protection register layout
`define SPC_SPR_BYTES         16
`define SPC_SPR_PROT          8'hFF
`define SPC_SPR_UNPROT        8'h00
`define SPC_S0A_HI            7
`define SPC_S0A_LO            6
`define SPC_S0B_HI            5
`define SPC_S0B_LO            4
`define SPC_S0_FIELD_PROT     2'h3

// pin filter: least stable time, rounded up to cycles
`define SPC_WP_FILT_NS        200
`define SPC_WP_FILT_CYC       ((`SPC_WP_FILT_NS + `SPC_CLK_PERIOD_NS - 1) / `SPC_CLK_PERIOD_NS)
`define SPC_FILT_W            5
// pin to protection delays, longest times, rounded down to cycles
`define SPC_PIN_ON_DELAY_NS   300
`define SPC_PIN_ON_DELAY_CYC  (`SPC_PIN_ON_DELAY_NS / `SPC_CLK_PERIOD_NS)
`define SPC_PIN_OFF_DELAY_NS  300
`define SPC_PIN_OFF_DELAY_CYC (`SPC_PIN_OFF_DELAY_NS / `SPC_CLK_PERIOD_NS)

`endif

// >>> src/spc_pkg.sv
// types shared by the sector protect control modules
`include "spc_defines.svh"

package spc_pkg;

	// command recognised from the fourth byte
	typedef enum logic [1:0] {
		SPC_CMD_NONE = 2'b00,
		SPC_CMD_EN   = 2'b01,
		SPC_CMD_DIS  = 2'b10
	} spc_cmd_e;

	// receiver state
	typedef struct packed {
		logic       sck_s1;
		logic       sck_s2;
		logic       sck_d;
		logic       cs_s1;
		logic       cs_s2;
		logic       cs_d;
		logic       mosi_s1;
		logic       mosi_s2;
		logic       wp_s1;
		logic       wp_s2;
		logic [2:0] bit_cnt;
		logic [7:0] shreg;
		logic       byte_v;
		logic [7:0] byte_data;
		logic       cs_rise;
		logic       partial;
	} spc_rx_s;

	// core state
	typedef struct packed {
		logic [2:0]                         cnt;
		logic                               bad;
		spc_cmd_e                           cmd;
		logic                               sw_en;
		logic                               wp_low;
		logic [`SPC_FILT_W-1:0]             filt_cnt;
		logic                               prot_status;
		logic                               spr_wr_ok;
		logic                               grant;
		logic                               deny;
		logic [`SPC_SPR_BYTES-1:0][7:0]     spr;
	} spc_core_s;

endpackage : spc_pkg

// >>> src/spc_link_if.sv
// byte and pin events from the serial receiver to the protection core
`timescale 1ns/10ps
`default_nettype none

interface spc_link_if;
	logic       byte_v;
	logic [7:0] byte_data;
	logic       cs_rise;
	logic       partial;
	logic       wp_n;

	modport rx (output byte_v, output byte_data, output cs_rise, output partial, output wp_n);
	modport core (input byte_v, input byte_data, input cs_rise, input partial, input wp_n);
endinterface : spc_link_if

`default_nettype wire

// >>> src/spc_spi_rx.sv
// serial receiver: pin synchronisers, clock edge finder, byte shifter
`timescale 1ns/10ps
`default_nettype none

module spc_spi_rx
	import spc_pkg::*;
(
	// clock and reset
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic ce,
	// pins
	input  wire logic spi_sck,
	input  wire logic spi_cs_n,
	input  wire logic spi_mosi,
	input  wire logic wp_n,
	// to the core
	spc_link_if.rx    lk
);

	spc_rx_s q;
	spc_rx_s d;

	// next state: first stages feed only second stages
	always_comb begin
		d         = q;
		d.sck_s1  = spi_sck;
		d.sck_s2  = q.sck_s1;
		d.sck_d   = q.sck_s2;
		d.cs_s1   = spi_cs_n;
		d.cs_s2   = q.cs_s1;
		d.cs_d    = q.cs_s2;
		d.mosi_s1 = spi_mosi;
		d.mosi_s2 = q.mosi_s1;
		d.wp_s1   = wp_n;
		d.wp_s2   = q.wp_s1;
		d.byte_v  = 1'b0;
		d.cs_rise = 1'b0;
		// deselect drops any partial byte
		if (q.cs_s2) begin
			d.bit_cnt = 3'h0;
		end else if (q.sck_s2 && !q.sck_d) begin
			// sample on rising sck, msb first (modes 0 and 3)
			d.shreg   = {q.shreg[6:0], q.mosi_s2};
			d.bit_cnt = q.bit_cnt + 3'h1;
			if (q.bit_cnt == 3'h7) begin
				d.byte_v    = 1'b1;
				d.byte_data = {q.shreg[6:0], q.mosi_s2};
			end
		end
		// deselect edge carries whether bits were left over
		if (q.cs_s2 && !q.cs_d) begin
			d.cs_rise = 1'b1;
			d.partial = (q.bit_cnt != 3'h0);
		end
	end

	// state register, chip select idles high
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q       <= '0;
			q.cs_s1 <= 1'b1;
			q.cs_s2 <= 1'b1;
			q.cs_d  <= 1'b1;
			q.wp_s1 <= 1'b1;
			q.wp_s2 <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	assign lk.byte_v    = q.byte_v;
	assign lk.byte_data = q.byte_data;
	assign lk.cs_rise   = q.cs_rise;
	assign lk.partial   = q.partial;
	assign lk.wp_n      = q.wp_s2;

endmodule : spc_spi_rx

`default_nettype wire

// >>> testbench/spc_host_model.sv
// serial host model: drives command frames onto the select, clock and data pins
`timescale 1ns/10ps
`default_nettype none

module spc_host_model (
	// clock
	input  wire logic ref_clk,
	// serial pins
	output logic      spi_sck,
	output logic      spi_cs_n,
	output logic      spi_mosi
);
	initial begin
		spi_sck  = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b1;
	end

	// bytes sent msb first, in order
	// sck high for 4 cycles and low for 8 give a 120 ns link period
	task automatic frame(input logic [39:0] bits, input int nbits);
		@(negedge ref_clk) spi_cs_n = 1'b0;
		for (int i = nbits - 1; i >= 0; i--) begin
			repeat (4) @(negedge ref_clk);
			spi_mosi = bits[i];
			repeat (4) @(negedge ref_clk);
			spi_sck = 1'b1;
			repeat (4) @(negedge ref_clk);
			spi_sck = 1'b0;
		end
		// hold time over: show the inverse so a stale bit cannot pass
		spi_mosi = ~spi_mosi;
	endtask : frame

	// select raised after the last bit
	task automatic end_frame();
		repeat (4) @(negedge ref_clk);
		spi_cs_n = 1'b1;
	endtask : end_frame
endmodule : spc_host_model

`default_nettype wire

// >>> testbench/sector_protect_control_tb_top.sv
// self-checking bench for the sector protect control block
`timescale 1ns/10ps
`default_nettype none

module sector_protect_control_tb_top;
	logic       ref_clk, arst_n, spi_sck, spi_cs_n, spi_mosi, wp_n;
	logic       op_req, op_on_spr, op_sub0b, op_grant, op_deny, spr_wr;
	logic [3:0] op_sector, spr_wr_idx;
	logic [7:0] spr_wr_data;
	logic       prot_status, sw_prot_on, spr_writable;
	int         num_errors, num_checks, cyc;
	// reference model state
	int         sw, pinlow;
	logic [7:0] spr_m [16];

	spc_host_model host_u (.ref_clk(ref_clk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi));

	spc_top dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .wp_n(wp_n), .op_req(op_req),
		.op_on_spr(op_on_spr), .op_sector(op_sector), .op_sub0b(op_sub0b),
		.op_grant(op_grant), .op_deny(op_deny), .spr_wr(spr_wr), .spr_wr_idx(spr_wr_idx),
		.spr_wr_data(spr_wr_data), .prot_status(prot_status), .sw_prot_on(sw_prot_on),
		.spr_writable(spr_writable));

	// 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// hang guard: whole run is far below this
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			num_errors++;
			summarize();
		end
	end

	// expected refusal from the model state
	function automatic logic exp_deny(input logic s, input logic [3:0] sec, input logic sub);
		logic f;
		if (s) return pinlow != 0;
		if (sec == 4'h0) f = sub ? (spr_m[0][5:4] == 2'b11) : (spr_m[0][7:6] == 2'b11);
		else f = (spr_m[sec] == 8'hFF);
		return f && (sw != 0 || pinlow != 0);
	endfunction : exp_deny

	task automatic op(input logic s, input logic [3:0] sec, input logic sub);
		logic g, d;
		@(negedge ref_clk) {op_req, op_on_spr, op_sector, op_sub0b} = {1'b1, s, sec, sub};
		@(negedge ref_clk) op_req = 1'b0;
		{g, d} = {op_grant, op_deny};
		@(negedge ref_clk) {g, d} = {g | op_grant, d | op_deny};
		check({g, d}, {~exp_deny(s, sec, sub), exp_deny(s, sec, sub)});
	endtask : op

	// every sector, both halves of sector 0, and the register itself
	task automatic sweep();
		for (int i = 0; i < 17; i++) op(1'b0, i[3:0], i == 16);
		op(1'b1, 4'h0, 1'b0);
	endtask : sweep

	task automatic wr(input logic [3:0] idx, input logic [7:0] data);
		@(negedge ref_clk) {spr_wr, spr_wr_idx, spr_wr_data} = {1'b1, idx, data};
		@(negedge ref_clk) spr_wr = 1'b0;
		if (pinlow == 0) spr_m[idx] = data;
	endtask : wr

	task automatic cmd(input logic [39:0] bits, input int n, input int new_sw);
		host_u.frame(bits, n);
		repeat (10) @(negedge ref_clk);
		// nothing changes while select is still low
		check(sw_prot_on, sw != 0);
		host_u.end_frame();
		repeat (8) @(negedge ref_clk);
		sw = new_sw;
		check(sw_prot_on, sw != 0);
		check(prot_status, sw != 0 || pinlow != 0);
	endtask : cmd

	// 30 cycles is the 300 ns pin to protection bound
	task automatic set_wp(input logic v);
		@(negedge ref_clk) wp_n = v;
		repeat (30) @(negedge ref_clk);
		pinlow = !v;
		check(prot_status, sw != 0 || pinlow != 0);
		check(spr_writable, v);
	endtask : set_wp

	// reset clears software protection and register bytes
	task automatic do_reset();
		arst_n = 1'b0;
		{sw, pinlow} = '0;
		for (int i = 0; i < 16; i++) spr_m[i] = 8'h00;
		repeat (12) @(negedge ref_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		check({sw_prot_on, prot_status, spr_writable}, 3'b001);
	endtask : do_reset

	initial begin
		{wp_n, op_req, op_on_spr, op_sector, op_sub0b} = {1'b1, 7'h00};
		{spr_wr, spr_wr_idx, spr_wr_data} = 13'h0000;
		{num_errors, num_checks, cyc} = '0;
		void'($urandom(94762));
		do_reset();
		for (int i = 1; i < 16; i++) wr(i[3:0], $urandom_range(1, 0) ? 8'hFF : 8'h00);
		wr(4'h0, {{2{$urandom_range(1, 0) == 1}}, 2'b11, 4'h5});
		sweep();
		cmd(40'h3D2A_7FA9, 32, 1);
		sweep();
		// broken disables: wrong byte, short, long, leftover bits
		cmd(40'h3D2A_7F9B, 32, 1);
		cmd(40'h3D_2A7F, 24, 1);
		cmd(40'h3D_2A7F_9A00, 40, 1);
		cmd(40'h3_D2A7_F9A0, 36, 1);
		cmd(40'h3D2A_7F9A, 32, 0);
		// short low pulse is filtered out
		@(negedge ref_clk) wp_n = 1'b0;
		repeat (10) @(negedge ref_clk);
		wp_n = 1'b1;
		repeat (30) @(negedge ref_clk);
		check(prot_status, 1'b0);
		check(spr_writable, 1'b1);
		set_wp(1'b0);
		sweep();
		wr(4'h3, ~spr_m[3]);
		sweep();
		cmd(40'h3D2A_7FA9, 32, 1);
		cmd(40'h3D2A_7F9A, 32, 1);
		set_wp(1'b1);
		sweep();
		cmd(40'h3D2A_7F9A, 32, 0);
		set_wp(1'b0);
		set_wp(1'b1);
		sweep();
		// power cycle with protection on must drop it again
		cmd(40'h3D2A_7FA9, 32, 1);
		do_reset();
		sweep();
		summarize();
	end
endmodule : sector_protect_control_tb_top

`default_nettype wire
